// [src/ppo_pwm_channel.sv]
// pulse width modulation channel with AHB-Lite register slave.
// assumes a single-slave AHB-Lite bus on clk_in; run input is asynchronous.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`default_nettype none
module ppo_pwm_channel
   import ppo_pkg::*;
#(
   parameter int PERIOD_DIV = 1
) (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        run_condition_in,
   output logic             pulse_first_out,
   output logic             pulse_second_out,
   output logic             irq_out
);
   import ppo_pkg::*;

   function automatic logic [15:0] duty_limit(input logic [15:0] code);
      duty_limit = (code <= CODE_LAST_FINE) ? DUTY_MAX_FINE : DUTY_MAX_COARSE;
   endfunction

   function automatic logic [15:0] duty_round(input logic [15:0] code, input logic [15:0] duty);
      duty_round = (code <= CODE_LAST_FINE) ? duty : (duty / DUTY_STEP) * DUTY_STEP;
   endfunction

   function automatic logic [31:0] period_cycles(input logic [15:0] code);
      logic [31:0] c;
      c = ppo_period_units(code[4:0]) * TICKS_PER_UNIT_W / 32'(PERIOD_DIV);
      period_cycles = (c == 32'h0) ? 32'h1 : c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus address phase
   logic [31:0] hrdata_r, hrdata_nxt;
   logic        wr_pend_r, wr_pend_nxt;
   logic [7:0]  wr_addr_r, wr_addr_nxt;
   logic [1:0]  ctrl_r, ctrl_nxt;
   logic [1:0]  cfg_r, cfg_nxt;
   logic [15:0] code_r, code_nxt;
   logic [15:0] duty_r, duty_nxt;
   logic [STAT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
   logic        irq_r, irq_nxt;
   ppo_state_t  state_r, state_nxt;
   logic [31:0] cnt_r, cnt_nxt, on_r, on_nxt, per_r, per_nxt;
   logic        sel_r, sel_nxt;
   logic        run_meta_r, run_sync_r, run_prev_r;
   logic        p0_r, p0_nxt, p1_r, p1_nxt;
   logic        addr_ok, start_req, avail, code_ok, duty_bad;
   logic [15:0] duty_eff;

   assign addr_ok = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);

   always_comb begin
      hrdata_nxt  = hrdata_r;
      wr_pend_nxt = addr_ok && hwrite_in;
      wr_addr_nxt = addr_ok ? haddr_in[7:0] : wr_addr_r;
      if (addr_ok && !hwrite_in) begin
         unique case (haddr_in[7:0])
            ADDR_CTRL:  hrdata_nxt = {30'h0, ctrl_r};
            ADDR_CFG:   hrdata_nxt = {30'h0, cfg_r};
            ADDR_CODE:  hrdata_nxt = {16'h0, code_r};
            ADDR_DUTY:  hrdata_nxt = {16'h0, duty_r};
            ADDR_STAT:  hrdata_nxt = {28'h0, stat_r};
            ADDR_MASK:  hrdata_nxt = {28'h0, mask_r};
            ADDR_STATE: hrdata_nxt = {28'h0, p1_r, p0_r, state_r};
            default:    hrdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         hrdata_r  <= 32'h0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h0;
      end else begin
         hrdata_r  <= hrdata_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
      end
   end

   // zero wait states, always okay: registered constants keep outputs flop-driven
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         hreadyout_out <= 1'b0;
         hresp_out     <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file, written in the data phase
   always_comb begin
      ctrl_nxt = ctrl_r;
      cfg_nxt  = cfg_r;
      code_nxt = code_r;
      duty_nxt = duty_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      if (wr_pend_r) begin
         unique case (wr_addr_r)
            ADDR_CTRL: ctrl_nxt = hwdata_in[1:0];
            ADDR_CFG:  cfg_nxt  = hwdata_in[1:0];
            ADDR_CODE: code_nxt = hwdata_in[15:0];
            ADDR_DUTY: duty_nxt = hwdata_in[15:0];
            ADDR_STAT: stat_nxt = stat_r & ~hwdata_in[STAT_W-1:0];
            ADDR_MASK: mask_nxt = hwdata_in[STAT_W-1:0];
            default:   ;
         endcase
      end
      // a new event beats a clear in the same cycle
      stat_nxt = stat_nxt | ev;
      irq_nxt  = |(stat_nxt & mask_nxt);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ctrl_r <= RESET_CTRL;
         cfg_r  <= RESET_CFG;
         code_r <= 16'h0;
         duty_r <= 16'h0;
         mask_r <= '0;
         stat_r <= '0;
         irq_r  <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cfg_r  <= cfg_nxt;
         code_r <= code_nxt;
         duty_r <= duty_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         irq_r  <= irq_nxt;
      end
   end
   assign hrdata_out = hrdata_r;
   assign irq_out    = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // run input synchroniser
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         run_meta_r <= 1'b0;
         run_sync_r <= 1'b0;
         run_prev_r <= 1'b0;
      end else begin
         run_meta_r <= run_condition_in;
         run_sync_r <= run_meta_r;
         run_prev_r <= run_sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // waveform generator
   assign start_req = run_sync_r && !run_prev_r && ctrl_r[CTRL_EN_BIT];
   assign avail     = ctrl_r[CTRL_SEL_BIT] ? cfg_r[CFG_CH2_BIT] : cfg_r[CFG_CH0_BIT];
   assign code_ok   = code_r <= CODE_LAST;
   assign duty_bad  = duty_r > duty_limit(code_r);
   // clamp keeps the output alive instead of stopping on a bad rewrite
   assign duty_eff  = duty_round(code_r, duty_bad ? duty_limit(code_r) : duty_r);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      per_nxt   = per_r;
      sel_nxt   = sel_r;
      on_nxt    = 32'((64'(per_r) * 64'(duty_eff)) / DUTY_FULL);
      ev        = '0;
      unique case (state_r)
         PPO_IDLE: begin
            cnt_nxt = 32'h0;
            if (start_req) begin
               if (!avail || !code_ok || duty_bad) begin
                  state_nxt        = PPO_FAULT;
                  ev[EV_ERR_BIT]   = 1'b1;
               end else begin
                  // code and duty already loaded by software
                  state_nxt        = PPO_RUN;
                  per_nxt          = period_cycles(code_r);
                  sel_nxt          = ctrl_r[CTRL_SEL_BIT];
                  on_nxt           = 32'((64'(period_cycles(code_r)) * 64'(duty_eff))
                                         / DUTY_FULL);
                  ev[EV_START_BIT] = 1'b1;
               end
            end
         end
         PPO_RUN: begin
            if (!run_sync_r || !ctrl_r[CTRL_EN_BIT]) begin
               state_nxt       = PPO_IDLE;
               cnt_nxt         = 32'h0;
               ev[EV_STOP_BIT] = 1'b1;
            end else begin
               cnt_nxt = (cnt_r >= per_r - 32'h1) ? 32'h0 : cnt_r + 32'h1;
               ev[EV_CLAMP_BIT] = duty_bad;
            end
         end
         PPO_FAULT: begin
            if (!run_sync_r) begin
               state_nxt = PPO_IDLE;
            end
         end
      endcase
      p0_nxt = (state_nxt == PPO_RUN) && !sel_nxt && (cnt_nxt < on_nxt);
      p1_nxt = (state_nxt == PPO_RUN) && sel_nxt && (cnt_nxt < on_nxt);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_r <= PPO_IDLE;
         cnt_r   <= 32'h0;
         per_r   <= 32'h1;
         on_r    <= 32'h0;
         sel_r   <= 1'b0;
         p0_r    <= 1'b0;
         p1_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         per_r   <= per_nxt;
         on_r    <= on_nxt;
         sel_r   <= sel_nxt;
         p0_r    <= p0_nxt;
         p1_r    <= p1_nxt;
      end
   end
   assign pulse_first_out  = p0_r;
   assign pulse_second_out = p1_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence seq_bad_start;
      start_req && state_r == PPO_IDLE && duty_bad;
   endsequence
   sequence seq_good_start;
      start_req && state_r == PPO_IDLE && avail && code_ok && !duty_bad;
   endsequence
   sequence seq_fault_quiet;
      state_r == PPO_FAULT ##1 !pulse_first_out && !pulse_second_out;
   endsequence

   chk_unavail_start: assert property (start_req && state_r == PPO_IDLE && !avail
      |=> state_r == PPO_FAULT && stat_r[EV_ERR_BIT])
      else $error("start on counter-owned channel did not fault");
   chk_period_load: assert property (seq_good_start
      |=> per_r == period_cycles($past(code_r)) && state_r == PPO_RUN)
      else $error("period not loaded from code table");
   chk_fine_limit: assert property (code_r <= CODE_LAST_FINE
      |-> duty_bad == (duty_r > DUTY_MAX_FINE))
      else $error("fine duty limit wrong");
   chk_coarse_limit: assert property (code_r > CODE_LAST_FINE
      |-> duty_bad == (duty_r > DUTY_MAX_COARSE))
      else $error("coarse duty limit wrong");
   chk_coarse_round: assert property (code_r > CODE_LAST_FINE
      |-> duty_eff % DUTY_STEP == 16'h0 && duty_eff <= duty_r)
      else $error("coarse duty not rounded to whole percent");
   chk_clamp_run: assert property (duty_bad && state_r == PPO_RUN
      && run_sync_r && ctrl_r[CTRL_EN_BIT] |=> state_r == PPO_RUN && stat_r[EV_CLAMP_BIT])
      else $error("bad duty while running stopped output");
   chk_bad_start: assert property (seq_bad_start
      |=> seq_fault_quiet)
      else $error("bad duty at start did not raise error");
   // the pin is registered together with the state, so both are read in one cycle
   chk_pin_needs_run: assert property ((pulse_first_out || pulse_second_out)
      |-> state_r == PPO_RUN && $past(run_sync_r))
      else $error("pulse without run condition");
   chk_pin_tracks: assert property (state_r == PPO_RUN
      |-> (pulse_first_out || pulse_second_out) == (cnt_r < on_r))
      else $error("pulse level does not follow on time");
   chk_stop_low: assert property (state_r == PPO_RUN && !run_sync_r
      |=> state_r == PPO_IDLE && cnt_r == 32'h0 && !pulse_first_out && !pulse_second_out)
      else $error("run drop did not stop output");
   chk_wrap: assert property (state_r == PPO_RUN && run_sync_r && ctrl_r[CTRL_EN_BIT]
      && cnt_r == per_r - 32'h1 |=> cnt_r == 32'h0)
      else $error("period counter did not wrap");
endmodule
`default_nettype wire

// [include/ppo_pkg.sv]
// constants shared by the pulse width modulation channel.
// assumes a 25 MHz system clock and a 32-bit AHB-Lite slave port.
`default_nettype none
package ppo_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets, one aligned word each
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_CFG   = 8'h04;
   localparam logic [7:0] ADDR_CODE  = 8'h08;
   localparam logic [7:0] ADDR_DUTY  = 8'h0c;
   localparam logic [7:0] ADDR_STAT  = 8'h10;
   localparam logic [7:0] ADDR_MASK  = 8'h14;
   localparam logic [7:0] ADDR_STATE = 8'h18;
   // field positions
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_SEL_BIT = 1;
   localparam int CFG_CH0_BIT  = 0;
   localparam int CFG_CH2_BIT  = 1;
   localparam int STAT_W       = 4;
   localparam int EV_ERR_BIT   = 0;
   localparam int EV_CLAMP_BIT = 1;
   localparam int EV_START_BIT = 2;
   localparam int EV_STOP_BIT  = 3;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  RESET_CTRL    = 2'h1;
   localparam logic [1:0]  RESET_CFG     = 2'h3;
   ////////////////////////////////////////////////////////////////////////////
   // control codes and duty limits
   localparam logic [15:0] CODE_LAST_FINE  = 16'h0013;
   localparam logic [15:0] CODE_LAST       = 16'h0018;
   localparam logic [15:0] DUTY_MAX_FINE   = 16'h03e7;
   localparam logic [15:0] DUTY_MAX_COARSE = 16'h03de;
   localparam logic [15:0] DUTY_STEP       = 16'h000a;
   localparam logic [63:0] DUTY_FULL       = 64'h0000_0000_0000_03e8;
   // timing: periods held in 10 us units, converted at the clock rate
   localparam int CLK_HZ        = 25_000_000;
   localparam int PERIOD_UNIT_US = 10;
   localparam int TICKS_PER_UNIT = CLK_HZ / 1_000_000 * PERIOD_UNIT_US;
   localparam logic [31:0] TICKS_PER_UNIT_W = 32'(TICKS_PER_UNIT);

   // period in 10 us units, 666.67 ms down to 0.02 ms
   function automatic logic [31:0] ppo_period_units(input logic [4:0] code);
      unique case (code)
         5'h00: ppo_period_units = 32'h0001_046b; // 666.67 ms
         5'h01: ppo_period_units = 32'h0000_c44b; // 502.51 ms
         5'h02: ppo_period_units = 32'h0000_5ffa; // 245.70 ms
         5'h03: ppo_period_units = 32'h0000_4009; // 163.93 ms
         5'h04: ppo_period_units = 32'h0000_2ffd; // 122.85 ms
         5'h05: ppo_period_units = 32'h0000_27fb; // 102.35 ms
         5'h06: ppo_period_units = 32'h0000_1400; // 51.20 ms
         5'h07: ppo_period_units = 32'h0000_0800; // 20.48 ms
         5'h08: ppo_period_units = 32'h0000_0400; // 10.24 ms
         5'h09: ppo_period_units = 32'h0000_01f0; // 4.96 ms
         5'h0a: ppo_period_units = 32'h0000_00f8; // 2.48 ms
         5'h0b: ppo_period_units = 32'h0000_00c8; // 2.00 ms
         5'h0c: ppo_period_units = 32'h0000_0090; // 1.44 ms
         5'h0d: ppo_period_units = 32'h0000_0060; // 0.96 ms
         5'h0e: ppo_period_units = 32'h0000_0050; // 0.80 ms
         5'h0f: ppo_period_units = 32'h0000_0040; // 0.64 ms
         5'h10: ppo_period_units = 32'h0000_0030; // 0.48 ms
         5'h11: ppo_period_units = 32'h0000_0020; // 0.32 ms
         5'h12: ppo_period_units = 32'h0000_0010; // 0.16 ms
         5'h13: ppo_period_units = 32'h0000_0008; // 0.08 ms
         5'h14: ppo_period_units = 32'h0000_0006; // 0.06 ms
         5'h15: ppo_period_units = 32'h0000_0005; // 0.05 ms
         5'h16: ppo_period_units = 32'h0000_0004; // 0.04 ms
         5'h17: ppo_period_units = 32'h0000_0003; // 0.03 ms
         5'h18: ppo_period_units = 32'h0000_0002; // 0.02 ms
         default: ppo_period_units = 32'h0000_0002;
      endcase
   endfunction

   typedef enum logic [1:0] {PPO_IDLE, PPO_RUN, PPO_FAULT} ppo_state_t;
endpackage
`default_nettype wire

// [dv/ppo_load_model.sv]
// load model on one pulse pin: measures the last high time and period in clocks.
// assumes the pin is a registered level sampled on the rising clock edge.
`default_nettype none
module ppo_load_model (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        pin_in,
   output logic      [31:0] high_len_out,
   output logic      [31:0] period_out,
   output logic      [31:0] rises_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        prev_r;
   logic [31:0] hl_r;
   logic [31:0] since_r;
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      if (reset_in) begin
         prev_r <= 1'b0;
         hl_r <= 32'h0;
         since_r <= 32'h0;
         high_len_out <= 32'h0;
         period_out <= 32'h0;
         rises_out <= 32'h0;
      end else begin
         prev_r <= pin_in;
         hl_r <= pin_in ? hl_r + 32'h1 : 32'h0;
         // a stop in mid-pulse also records a short high time
         if (!pin_in && prev_r) begin
            high_len_out <= hl_r;
         end
         if (pin_in && !prev_r) begin
            period_out <= since_r;
            since_r <= 32'h1;
            rises_out <= rises_out + 32'h1;
         end else begin
            since_r <= since_r + 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the pulse width modulation channel.
// assumes zero wait state AHB-Lite answers; load models watch both pins.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ppo_pkg::*;
   localparam int LIMIT = 20000;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        run = 1'b0;
   logic        p1;
   logic        p2;
   logic        irq;
   logic [31:0] m1_high, m1_per, m1_rises, m2_high, m2_per, m2_rises, r1;
   int          fails = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   always #20 clk = ~clk;
   // period divider 10: code 19 gives 200 clocks, code 20 150, code 24 50
   ppo_pwm_channel #(.PERIOD_DIV(10)) dut (.clk_in(clk), .reset_in(rst), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .run_condition_in(run), .pulse_first_out(p1),
      .pulse_second_out(p2), .irq_out(irq));
   ppo_load_model load1 (.clk_in(clk), .reset_in(rst), .pin_in(p1), .high_len_out(m1_high),
      .period_out(m1_per), .rises_out(m1_rises));
   ppo_load_model load2 (.clk_in(clk), .reset_in(rst), .pin_in(p2), .high_len_out(m2_high),
      .period_out(m2_per), .rises_out(m2_rises));
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      hsel <= 1'b1;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] junk;
      bus(1'b1, a, d, junk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      check(v, exp);
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic pwm_run(input logic [31:0] code, input logic [31:0] duty, input int n);
      wr(ADDR_CODE, code);
      wr(ADDR_DUTY, duty);
      run <= 1'b1;
      repeat (n) @(posedge clk);
   endtask
   task automatic pwm_stop;
      run <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         $display("ERROR t=%0t run hung", $time);
         tally_and_finish;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk(ADDR_CTRL, {30'h0, RESET_CTRL});
      rd_chk(ADDR_CFG, {30'h0, RESET_CFG});
      rd_chk(ADDR_STAT, 32'h0);
      rd_chk(8'h1c, 32'h0);
      $display("test reset values done");
      pwm_run(32'h13, 32'h1f4, 700);
      check(m1_high, 32'h64);
      check(m1_per, 32'hc8);
      rd_chk(ADDR_STAT, 32'h4);
      wr(ADDR_DUTY, 32'h3e7);
      repeat (450) @(posedge clk);
      check(m1_high, 32'hc7);
      wr(ADDR_DUTY, 32'h5dc);
      repeat (450) @(posedge clk);
      check(m1_high, 32'hc7);
      rd_chk(ADDR_STAT, 32'h6);
      run <= 1'b0;
      repeat (4) @(posedge clk);
      check({31'h0, p1}, 32'h0);
      r1 = m1_rises;
      repeat (300) @(posedge clk);
      check(m1_rises, r1);
      rd_chk(ADDR_STAT, 32'he);
      wr(ADDR_STAT, 32'hf);
      rd_chk(ADDR_STAT, 32'h0);
      $display("test fine duty done");
      pwm_run(32'h18, 32'h3de, 300);
      check(m1_high, 32'h31);
      check(m1_per, 32'h32);
      pwm_stop();
      wr(ADDR_CTRL, 32'h3);
      r1 = m1_rises;
      pwm_run(32'h14, 32'h22b, 500);
      check(m2_high, 32'h52);
      check(m2_per, 32'h96);
      check(m1_rises, r1);
      wr(ADDR_DUTY, 32'h3e3);
      repeat (400) @(posedge clk);
      check(m2_high, 32'h94);
      pwm_stop();
      $display("test coarse duty done");
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_MASK, 32'h1);
      wr(ADDR_STAT, 32'hf);
      r1 = m1_rises;
      pwm_run(32'h13, 32'h3e8, 20);
      rd_chk(ADDR_STATE, 32'h2);
      check({31'h0, irq}, 32'h1);
      check(m1_rises, r1);
      pwm_stop();
      wr(ADDR_STAT, 32'hf);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      pwm_run(32'h18, 32'h3df, 20);
      rd_chk(ADDR_STATE, 32'h2);
      pwm_stop();
      pwm_run(32'h19, 32'h1f4, 20);
      rd_chk(ADDR_STATE, 32'h2);
      pwm_stop();
      wr(ADDR_CFG, 32'h2);
      pwm_run(32'h13, 32'h1f4, 20);
      rd_chk(ADDR_STATE, 32'h2);
      check(m1_rises, r1);
      pwm_stop();
      rd_chk(ADDR_STATE, 32'h0);
      // enable cleared: a run edge must not start the channel
      wr(ADDR_CFG, 32'h3);
      wr(ADDR_CTRL, 32'h0);
      pwm_run(32'h13, 32'h1f4, 20);
      rd_chk(ADDR_STATE, 32'h0);
      check(m1_rises, r1);
      pwm_stop();
      $display("test refused starts done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
